/* design/ubrg_pkg.sv */
// Package for the serial baud generator and receive-line sampler.
// Assumes a 32-bit APB bus with a 12-bit byte address.
package ubrg_pkg;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned REG_W = 8;
    localparam int unsigned PHASE_W = 6;

    // Register indices; byte address is four times the index
    localparam logic [ADDR_W-1:0] RX_CTRL_IDX = 12'h018;
    localparam logic [ADDR_W-1:0] TX_CTRL_IDX = 12'h098;
    localparam logic [ADDR_W-1:0] BAUD_DIV_IDX = 12'h099;
    localparam logic [ADDR_W-1:0] SAMPLE_STAT_IDX = 12'h09a;
    localparam logic [ADDR_W-1:0] RX_CTRL_ADDR = 12'h060;
    localparam logic [ADDR_W-1:0] TX_CTRL_ADDR = 12'h260;
    localparam logic [ADDR_W-1:0] BAUD_DIV_ADDR = 12'h264;
    localparam logic [ADDR_W-1:0] SAMPLE_STAT_ADDR = 12'h268;

    localparam logic [REG_W-1:0] RX_CTRL_RST = 8'h00;
    localparam logic [REG_W-1:0] TX_CTRL_RST = 8'h02;
    localparam logic [REG_W-1:0] BAUD_DIV_RST = 8'h00;
    localparam logic [REG_W-1:0] RX_CTRL_WMASK = 8'hf0;
    localparam logic [REG_W-1:0] TX_CTRL_WMASK = 8'hf5;
    // Transmit shift register always empty here: no transmit path
    localparam logic [REG_W-1:0] TX_CTRL_RO_SET = 8'h02;

    localparam int unsigned PORT_EN_BIT = 7;
    localparam int unsigned SYNC_BIT = 4;
    localparam int unsigned HIGH_SPEED_BIT = 2;

    // Ticks of the divisor timer per bit, less one
    localparam logic [PHASE_W-1:0] LOW_ASYNC_LAST = 6'h3f;
    localparam logic [PHASE_W-1:0] HIGH_ASYNC_LAST = 6'h0f;
    localparam logic [PHASE_W-1:0] SYNC_LAST = 6'h03;

    // Low speed: x16 clock period is four ticks; falling edges 7, 8, 9
    localparam logic [PHASE_W-1:0] LOW_SAMPLE_A = 6'h1b;
    localparam logic [PHASE_W-1:0] LOW_SAMPLE_B = 6'h1f;
    localparam logic [PHASE_W-1:0] LOW_SAMPLE_C = 6'h23;
    // High speed: x4 clock high on ticks 0-1 and low on 2-3 of each four;
    // second rise after the first fall is tick 8, so sample on 5, 6, 7
    localparam logic [PHASE_W-1:0] HIGH_SAMPLE_A = 6'h05;
    localparam logic [PHASE_W-1:0] HIGH_SAMPLE_B = 6'h06;
    localparam logic [PHASE_W-1:0] HIGH_SAMPLE_C = 6'h07;

    typedef enum logic [1:0] {
        UBRG_ASYNC_LOW = 2'b00,
        UBRG_ASYNC_HIGH = 2'b01,
        UBRG_SYNC_MASTER = 2'b10
    } ubrg_mode_e;
endpackage : ubrg_pkg

/* design/ubrg_baud_sampler.sv */
// Baud rate generator with three-sample majority receive sampler.
// Assumes an APB master on ref_clk and a receive line synchronous to it.
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module ubrg_baud_sampler (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ubrg_pkg::ADDR_W-1:0] paddr,
    input wire logic [ubrg_pkg::DATA_W-1:0] pwdata,
    output logic [ubrg_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic serialInputPin,
    output logic overSampleTick,
    output logic bitTick,
    output logic rxBit,
    output logic rxBitValid
);
    logic [ubrg_pkg::REG_W-1:0] rxCtrl_q;
    logic [ubrg_pkg::REG_W-1:0] txCtrl_q;
    logic [ubrg_pkg::REG_W-1:0] baudDiv_q;
    logic [ubrg_pkg::REG_W-1:0] timer_q;
    logic [ubrg_pkg::PHASE_W-1:0] phase_q;
    logic [2:0] samples_q;
    logic [1:0] sampleCnt_q;
    logic [ubrg_pkg::DATA_W-1:0] prdata_q;
    logic pslverr_q;
    logic tickOut_q;
    logic bitTick_q;
    logic rxBit_q;
    logic rxBitValid_q;

    logic setup;
    logic access;
    logic wrRx;
    logic wrTx;
    logic wrDiv;
    logic mapped;
    logic timerTick;
    logic phaseLast;
    logic sampleNow;
    logic sampleLast;
    logic rxActive;
    logic [ubrg_pkg::PHASE_W-1:0] lastPhase;
    logic [2:0] newSamples;
    ubrg_pkg::ubrg_mode_e mode;

    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign wrRx = access & pwrite & (paddr == ubrg_pkg::RX_CTRL_ADDR);
    assign wrTx = access & pwrite & (paddr == ubrg_pkg::TX_CTRL_ADDR);
    assign wrDiv = access & pwrite & (paddr == ubrg_pkg::BAUD_DIV_ADDR);
    assign mapped = (paddr == ubrg_pkg::RX_CTRL_ADDR) || (paddr == ubrg_pkg::TX_CTRL_ADDR)
        || (paddr == ubrg_pkg::BAUD_DIV_ADDR) || (paddr == ubrg_pkg::SAMPLE_STAT_ADDR);

    // Zero wait states: read data is captured in the setup cycle
    assign pready = access;
    assign prdata = prdata_q;
    assign pslverr = access & pslverr_q;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_q <= '0;
            pslverr_q <= 1'b0;
        end else if (setup) begin
            pslverr_q <= ~mapped;
            unique case (paddr)
                ubrg_pkg::RX_CTRL_ADDR: prdata_q <= {24'h000000, rxCtrl_q};
                ubrg_pkg::TX_CTRL_ADDR: prdata_q <= {24'h000000, txCtrl_q | ubrg_pkg::TX_CTRL_RO_SET};
                ubrg_pkg::BAUD_DIV_ADDR: prdata_q <= {24'h000000, baudDiv_q};
                ubrg_pkg::SAMPLE_STAT_ADDR: prdata_q <= {24'h000000, 1'b0, sampleCnt_q, samples_q, rxBit_q,
                    rxBitValid_q};
                default: prdata_q <= '0;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rxCtrl_q <= ubrg_pkg::RX_CTRL_RST;
            txCtrl_q <= ubrg_pkg::TX_CTRL_RST & ubrg_pkg::TX_CTRL_WMASK;
            baudDiv_q <= ubrg_pkg::BAUD_DIV_RST;
        end else begin
            if (wrRx) begin
                rxCtrl_q <= pwdata[ubrg_pkg::REG_W-1:0] & ubrg_pkg::RX_CTRL_WMASK;
            end
            if (wrTx) begin
                txCtrl_q <= pwdata[ubrg_pkg::REG_W-1:0] & ubrg_pkg::TX_CTRL_WMASK;
            end
            if (wrDiv) begin
                baudDiv_q <= pwdata[ubrg_pkg::REG_W-1:0];
            end
        end
    end

    // Sync mode outranks the high-speed select
    always_comb begin
        if (txCtrl_q[ubrg_pkg::SYNC_BIT]) begin
            mode = ubrg_pkg::UBRG_SYNC_MASTER;
        end else if (txCtrl_q[ubrg_pkg::HIGH_SPEED_BIT]) begin
            mode = ubrg_pkg::UBRG_ASYNC_HIGH;
        end else begin
            mode = ubrg_pkg::UBRG_ASYNC_LOW;
        end
    end

    always_comb begin
        unique case (mode)
            ubrg_pkg::UBRG_ASYNC_LOW: lastPhase = ubrg_pkg::LOW_ASYNC_LAST;
            ubrg_pkg::UBRG_ASYNC_HIGH: lastPhase = ubrg_pkg::HIGH_ASYNC_LAST;
            ubrg_pkg::UBRG_SYNC_MASTER: lastPhase = ubrg_pkg::SYNC_LAST;
            default: lastPhase = ubrg_pkg::LOW_ASYNC_LAST;
        endcase
    end

    // Timer ticks once every divisor+1 clocks
    assign timerTick = (timer_q == '0) & ~wrDiv;
    assign phaseLast = phase_q >= lastPhase;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            timer_q <= ubrg_pkg::BAUD_DIV_RST;
        end else if (wrDiv) begin
            timer_q <= pwdata[ubrg_pkg::REG_W-1:0];
        end else if (timerTick) begin
            timer_q <= baudDiv_q;
        end else begin
            timer_q <= timer_q - 8'h01;
        end
    end

    // Mode change restarts the bit phase so it never exceeds the new ratio
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_q <= '0;
        end else if (wrDiv || wrTx) begin
            phase_q <= '0;
        end else if (timerTick) begin
            phase_q <= phaseLast ? '0 : phase_q + 6'h01;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tickOut_q <= 1'b0;
            bitTick_q <= 1'b0;
        end else begin
            tickOut_q <= timerTick & ~txCtrl_q[ubrg_pkg::SYNC_BIT];
            bitTick_q <= timerTick & phaseLast & ~wrTx;
        end
    end
    assign overSampleTick = tickOut_q;
    assign bitTick = bitTick_q;

    assign rxActive = rxCtrl_q[ubrg_pkg::PORT_EN_BIT] & ~txCtrl_q[ubrg_pkg::SYNC_BIT];

    always_comb begin
        sampleNow = 1'b0;
        sampleLast = 1'b0;
        if (mode == ubrg_pkg::UBRG_ASYNC_LOW) begin
            sampleNow = (phase_q == ubrg_pkg::LOW_SAMPLE_A) || (phase_q == ubrg_pkg::LOW_SAMPLE_B)
                || (phase_q == ubrg_pkg::LOW_SAMPLE_C);
            sampleLast = phase_q == ubrg_pkg::LOW_SAMPLE_C;
        end else if (mode == ubrg_pkg::UBRG_ASYNC_HIGH) begin
            sampleNow = (phase_q == ubrg_pkg::HIGH_SAMPLE_A) || (phase_q == ubrg_pkg::HIGH_SAMPLE_B)
                || (phase_q == ubrg_pkg::HIGH_SAMPLE_C);
            sampleLast = phase_q == ubrg_pkg::HIGH_SAMPLE_C;
        end
        sampleNow = sampleNow & timerTick & rxActive & ~wrTx;
        sampleLast = sampleLast & sampleNow;
    end

    assign newSamples = {samples_q[1:0], serialInputPin};

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            samples_q <= 3'h7;
            sampleCnt_q <= 2'h0;
        end else if (sampleNow) begin
            samples_q <= newSamples;
            sampleCnt_q <= sampleLast ? 2'h0 : sampleCnt_q + 2'h1;
        end
    end

    // Two of three agree; idle line reads high after reset
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rxBit_q <= 1'b1;
            rxBitValid_q <= 1'b0;
        end else begin
            rxBitValid_q <= sampleLast;
            if (sampleLast) begin
                rxBit_q <= (newSamples[0] & newSamples[1]) | (newSamples[0] & newSamples[2])
                    | (newSamples[1] & newSamples[2]);
            end
        end
    end
    assign rxBit = rxBit_q;
    assign rxBitValid = rxBitValid_q;

    AST_TIMER_RELOAD: assert property (@(posedge ref_clk) disable iff (!rst_n)
        timerTick |=> (timer_q == $past(baudDiv_q)) || $past(wrDiv))
        else $error("Baud timer did not reload from divisor");
    AST_DIV_WRITE_RESTART: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wrDiv |=> (timer_q == $past(pwdata[7:0])) && (phase_q == '0) && !bitTick_q)
        else $error("Divisor write did not restart the timer");
    AST_DIV_ZERO: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (baudDiv_q == '0) && (timer_q == '0) && !wrDiv |=> (timer_q == '0))
        else $error("Divisor zero did not tick every clock");
    AST_LOW_RATIO: assert property (@(posedge ref_clk) disable iff (!rst_n)
        timerTick && (mode == ubrg_pkg::UBRG_ASYNC_LOW) && !wrTx && (phase_q == 6'h3f) |=>
        (phase_q == '0) && bitTick_q)
        else $error("Low speed bit period is not 64 ticks");
    AST_HIGH_RATIO: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (mode == ubrg_pkg::UBRG_ASYNC_HIGH) && !$past(wrTx) && $past(mode == ubrg_pkg::UBRG_ASYNC_HIGH) |->
        phase_q <= 6'h0f)
        else $error("High speed phase exceeds 16 ticks");
    AST_SYNC_RATIO: assert property (@(posedge ref_clk) disable iff (!rst_n)
        timerTick && txCtrl_q[4] && !wrTx && (phase_q == 6'h03) |=> (phase_q == '0) && bitTick_q && !overSampleTick)
        else $error("Sync bit period is not 4 ticks");
    AST_SAMPLE_LOW: assert property (@(posedge ref_clk) disable iff (!rst_n)
        sampleNow && !txCtrl_q[2] |-> (phase_q == 6'h1b) || (phase_q == 6'h1f) || (phase_q == 6'h23))
        else $error("Low speed sample taken off the 7th to 9th edge");
    AST_SAMPLE_HIGH: assert property (@(posedge ref_clk) disable iff (!rst_n)
        sampleNow && txCtrl_q[2] |-> (phase_q >= 6'h05) && (phase_q <= 6'h07))
        else $error("High speed sample taken outside ticks 5 to 7");
    AST_MAJORITY: assert property (@(posedge ref_clk) disable iff (!rst_n)
        rxBitValid_q |-> rxBit_q == ((samples_q[0] & samples_q[1]) | (samples_q[0] & samples_q[2])
        | (samples_q[1] & samples_q[2])))
        else $error("Received bit disagrees with sample majority");
    AST_OVERSAMPLE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        bitTick_q && !txCtrl_q[4] && !$past(wrTx) |-> overSampleTick)
        else $error("Bit tick without an oversample tick");

    // Timer never runs above the divisor, so a write can never stretch a period
    AST_DIV_STORE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wrDiv |=> (baudDiv_q == $past(pwdata[ubrg_pkg::REG_W-1:0])))
        else $error("Divisor write not stored");
    AST_TIMER_BOUND: assert property (@(posedge ref_clk) disable iff (!rst_n)
        timer_q <= baudDiv_q)
        else $error("Baud timer above the divisor");
    AST_TIMER_COUNT: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !timerTick && !wrDiv |=> (timer_q == $past(timer_q) - 8'h01))
        else $error("Baud timer did not count down");
    AST_PHASE_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !timerTick && !wrDiv && !wrTx |=> $stable(phase_q))
        else $error("Bit phase moved without a timer tick");
    AST_BIT_TICK_SOURCE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        bitTick_q |-> $past(timerTick) && $past(phaseLast))
        else $error("Bit tick without a last-phase timer tick");
    AST_OVERSAMPLE_SOURCE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        overSampleTick |-> $past(timerTick) && !$past(txCtrl_q[ubrg_pkg::SYNC_BIT]))
        else $error("Oversample tick without an async timer tick");
    AST_ASYNC_OVERSAMPLE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        timerTick && !txCtrl_q[ubrg_pkg::SYNC_BIT] |=> overSampleTick)
        else $error("Async timer tick gave no oversample tick");
    AST_SYNC_MODE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        txCtrl_q[ubrg_pkg::SYNC_BIT] |->
        (mode == ubrg_pkg::UBRG_SYNC_MASTER) && (lastPhase == ubrg_pkg::SYNC_LAST))
        else $error("Sync mode followed the high-speed select");
    AST_SYNC_QUIET: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $past(txCtrl_q[ubrg_pkg::SYNC_BIT]) |-> !overSampleTick)
        else $error("Oversample tick in sync mode");
    AST_SYNC_PHASE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        txCtrl_q[ubrg_pkg::SYNC_BIT] && !$past(wrTx) && $past(txCtrl_q[ubrg_pkg::SYNC_BIT]) |->
        (phase_q <= ubrg_pkg::SYNC_LAST))
        else $error("Sync phase exceeds four ticks");
    AST_SAMPLE_ENABLE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        sampleNow |-> rxCtrl_q[ubrg_pkg::PORT_EN_BIT] && !txCtrl_q[ubrg_pkg::SYNC_BIT] && timerTick)
        else $error("Sample taken while the receiver is off");
    AST_SAMPLE_SHIFT: assert property (@(posedge ref_clk) disable iff (!rst_n)
        sampleNow |=> (samples_q[0] == $past(serialInputPin)) && (samples_q[2:1] == $past(samples_q[1:0])))
        else $error("Sample not shifted in from the line");
    AST_VALID_SOURCE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        rxBitValid_q |-> $past(sampleLast))
        else $error("Bit valid without a third sample");
    AST_RXBIT_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !rxBitValid_q |-> $stable(rxBit_q))
        else $error("Received bit changed without a valid pulse");
    AST_VALID_SPACING: assert property (@(posedge ref_clk) disable iff (!rst_n)
        rxBitValid_q |=> !rxBitValid_q)
        else $error("Two bit decisions in adjacent cycles");
endmodule : ubrg_baud_sampler

`default_nettype wire

/* sim/ubrg_tx_model.sv */
// Remote transmitter model driving the receive line.
// Assumes it shares bit timing with the receiver; new level at each bitTick.
`timescale 1ns/1ps
`default_nettype none
module ubrg_tx_model (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic bitTick,
    input wire logic overSampleTick,
    input wire logic lineLevel,
    input wire logic [6:0] glitchLo,
    input wire logic [6:0] glitchHi,
    output logic serialInputPin
);
    logic lvl_q;
    logic [6:0] lo_q;
    logic [6:0] hi_q;
    logic [6:0] cnt_q;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            lvl_q <= 1'b1;
            lo_q <= 7'h7f;
            hi_q <= 7'h00;
        end else if (bitTick) begin
            lvl_q <= lineLevel;
            lo_q <= glitchLo;
            hi_q <= glitchHi;
        end
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 7'h00;
        end else if (bitTick) begin
            cnt_q <= 7'h00;
        end else if (overSampleTick) begin
            cnt_q <= cnt_q + 7'h01;
        end
    end
    // Glitch window inverts the line, as noise on the wire would
    assign serialInputPin = lvl_q ^ (cnt_q >= lo_q && cnt_q <= hi_q);
endmodule : ubrg_tx_model
`default_nettype wire

/* sim/ubrg_baud_sampler_tb.sv */
// Self-checking bench for the baud generator and receive sampler.
// Assumes the transmitter model on the receive line and an APB master here.
`timescale 1ns/1ps
`default_nettype none
module ubrg_baud_sampler_tb;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, serialInputPin, overSampleTick, bitTick, rxBit, rxBitValid;
    logic lineLevel = 1'b1;
    logic [6:0] glitchLo = 7'h7f;
    logic [6:0] glitchHi = 7'h00;
    logic [31:0] rd;
    logic err;
    logic rl;
    int bad_count = 0;
    int checked = 0;
    int n;
    ubrg_baud_sampler dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .serialInputPin(serialInputPin), .overSampleTick(overSampleTick),
        .bitTick(bitTick), .rxBit(rxBit), .rxBitValid(rxBitValid));
    ubrg_tx_model model_u (.ref_clk(ref_clk), .rst_n(rst_n), .bitTick(bitTick),
        .overSampleTick(overSampleTick), .lineLevel(lineLevel), .glitchLo(glitchLo),
        .glitchHi(glitchHi), .serialInputPin(serialInputPin));
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic finish_test;
        $display("checked=%0d bad_count=%0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wait_ev(input logic pickValid);
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while ((pickValid ? rxBitValid : bitTick) !== 1'b1 && n < 20000);
        if (n >= 20000) bad_count++;
    endtask : wait_ev
    function automatic int exp_bit(input int m, input int d);
        return (m == 0 ? 64 : (m == 1 ? 16 : 4)) * (d + 1);
    endfunction : exp_bit
    task automatic meas(input int m, input int d);
        int bp, os;
        bp = 0;
        os = 0;
        wait_ev(1'b0);
        do begin
            @(negedge ref_clk);
            bp++;
            if (overSampleTick === 1'b1) os++;
        end while (bitTick !== 1'b1 && bp < 20000);
        chk(bp, exp_bit(m, d));
        chk(os, m == 0 ? 64 : (m == 1 ? 16 : 0));
    endtask : meas
    task automatic rxcase(input logic lvl, input int lo, input int hi, input logic e);
        @(posedge ref_clk);
        lineLevel <= lvl;
        glitchLo <= 7'(lo);
        glitchHi <= 7'(hi);
        wait_ev(1'b0);
        wait_ev(1'b1);
        chk({31'h0, rxBit}, {31'h0, e});
    endtask : rxcase
    initial begin
        int d;
        n = $urandom(16695);
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        apb(1'b0, ubrg_pkg::RX_CTRL_ADDR, 32'h0);
        chk(rd, 32'h00);
        apb(1'b0, ubrg_pkg::TX_CTRL_ADDR, 32'h0);
        chk(rd, 32'h02);
        apb(1'b0, ubrg_pkg::BAUD_DIV_ADDR, 32'h0);
        chk(rd, 32'h00);
        apb(1'b1, ubrg_pkg::RX_CTRL_ADDR, 32'hff);
        apb(1'b0, ubrg_pkg::RX_CTRL_ADDR, 32'h0);
        chk(rd, 32'hf0);
        apb(1'b1, ubrg_pkg::TX_CTRL_ADDR, 32'hff);
        apb(1'b0, ubrg_pkg::TX_CTRL_ADDR, 32'h0);
        chk(rd, 32'hf7);
        apb(1'b1, 12'h100, 32'h5a);
        chk({31'h0, err}, 32'h1);
        apb(1'b0, 12'h100, 32'h0);
        chk({rd[30:0], err}, 32'h1);
        // Modes: async low, async high, sync, sync with high speed set
        for (int m = 0; m < 4; m++) begin
            for (int r = 0; r < 3; r++) begin
                d = (r == 0) ? 0 : ((r == 1 && m > 0) ? 255 : int'($urandom_range(15, 1)));
                apb(1'b1, ubrg_pkg::TX_CTRL_ADDR, m == 0 ? 32'h00 : (m == 1 ? 32'h04 : (m == 2 ? 32'h10 : 32'h14)));
                apb(1'b1, ubrg_pkg::BAUD_DIV_ADDR, 32'(d));
                apb(1'b0, ubrg_pkg::BAUD_DIV_ADDR, 32'h0);
                chk(rd, 32'(d));
                meas(m, d);
            end
        end
        // A slow period in progress must not delay the new rate
        apb(1'b1, ubrg_pkg::TX_CTRL_ADDR, 32'h04);
        apb(1'b1, ubrg_pkg::BAUD_DIV_ADDR, 32'hff);
        apb(1'b1, ubrg_pkg::BAUD_DIV_ADDR, 32'h00);
        wait_ev(1'b0);
        chk(32'(n <= 20), 32'h1);
        // Low speed is the recommended setting for reception
        apb(1'b1, ubrg_pkg::TX_CTRL_ADDR, 32'h00);
        // Nonzero divisor keeps the model's tick count equal to the bit phase
        apb(1'b1, ubrg_pkg::BAUD_DIV_ADDR, 32'h01);
        rl = 1'($urandom);
        rxcase(1'b0, 1, 0, 1'b0);
        rxcase(1'b1, 1, 0, 1'b1);
        rxcase(rl, 31, 31, rl);
        rxcase(1'b1, 24, 38, 1'b0);
        rxcase(1'b0, 24, 38, 1'b1);
        rxcase(1'b1, 27, 31, 1'b0);
        apb(1'b0, ubrg_pkg::SAMPLE_STAT_ADDR, 32'h0);
        chk(rd, 32'h04);
        rxcase(1'b0, 31, 35, 1'b1);
        apb(1'b1, ubrg_pkg::TX_CTRL_ADDR, 32'h04);
        apb(1'b1, ubrg_pkg::BAUD_DIV_ADDR, 32'h03);
        rxcase(rl, 6, 6, rl);
        rxcase(1'b0, 3, 9, 1'b1);
        rxcase(1'b1, 1, 0, 1'b1);
        rxcase(1'b1, 5, 6, 1'b0);
        rxcase(1'b0, 6, 7, 1'b1);
        finish_test();
    end
    // Planned traffic is near 20000 cycles; allow about four and a half times that
    initial begin
        #900000;
        bad_count++;
        finish_test();
    end
endmodule : ubrg_baud_sampler_tb
`default_nettype wire
